// ===== rtl/pot_cmd_defs.vh
// Constants for the serial potentiometer command decoder.
// Included by the decoder design file of the block only; definitions only.
`ifndef POT_CMD_DEFS_VH
`define POT_CMD_DEFS_VH

// Position register width and reset image
`define POS_W 10
`define NV_RESET_VAL 10'h000
`define NV_COUNT 4

// Frame bit counts
`define CNT_ID_DONE 6'h07
`define CNT_INSTR_DONE 6'h0F
`define LEN_SHORT 6'h10
`define LEN_LONG 6'h20

// Identification byte fields
`define ID_TYPE_HI 7
`define ID_TYPE_LO 4
`define ID_ADDR_HI 2
`define ID_ADDR_LO 1
`define ID_RW 0

// Instruction byte fields and codes
`define INS_OP_HI 7
`define INS_OP_LO 4
`define INS_SEL_HI 3
`define INS_SEL_LO 2
`define INS_RD_WIPER 8'h80
`define INS_WR_WIPER 8'hA0
`define INS_RD_STATUS 8'h41
`define OP_RD_NV 4'hA
`define OP_WR_NV 4'hC
`define OP_TRANSFER_TO_WIPER 4'hC
`define OP_TRANSFER_TO_NV 4'hE

// Command one-hot bit positions
`define CMD_W 7
`define C_RD_WIPER 0
`define C_WR_WIPER 1
`define C_RD_NV 2
`define C_WR_NV 3
`define C_TRANSFER_TO_WIPER 4
`define C_TRANSFER_TO_NV 5
`define C_RD_STATUS 6

// Timing
`define CLOCK_HZ 20000000
`define NV_WRITE_TIME_US 10000
`define WIPER_DELAY_NS 1000

// Synchroniser reset image {cs_n, sck, si, wp_n, pin_addr[1:0]}
`define SYNC_INIT 6'h24

`endif

// ===== rtl/pin_sync.v
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes one clock domain; the filtered level moves when stages two and three agree.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter W = 6,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input wire clock,
	input wire arst_n,
	input wire [W-1:0] pin_in,
	output wire [W-1:0] level
);

	genvar g;
	generate
		for (g = 0; g < W; g = g + 1)
		begin : bit_sync
			reg s1_q;
			reg s2_q;
			reg s3_q;
			reg lvl_q;
			always @(posedge clock or negedge arst_n)
			begin
				if (!arst_n)
				begin
					s1_q <= INIT[g];
					s2_q <= INIT[g];
					s3_q <= INIT[g];
					lvl_q <= INIT[g];
				end
				else
				begin
					s1_q <= pin_in[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q)
						lvl_q <= s3_q;
				end
			end
			assign level[g] = lvl_q;
		end
	endgenerate

endmodule // pin_sync

`default_nettype wire

// ===== rtl/cycle_timer.v
// Retriggerable down-counter giving a busy level and an expiry pulse.
// Assumes start is a one-cycle pulse from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module cycle_timer #(
	parameter integer CYCLES = 20
) (
	input wire clock,
	input wire arst_n,
	input wire start,
	output reg busy,
	output reg done
);

	localparam [31:0] LOAD = CYCLES - 1;
	reg [31:0] cnt_q;

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_q <= 32'h0;
			busy <= 1'b0;
			done <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (start)
			begin
				cnt_q <= LOAD;
				busy <= 1'b1;
			end
			else if (busy)
			begin
				if (cnt_q == 32'h0)
				begin
					busy <= 1'b0;
					done <= 1'b1;
				end
				else
					cnt_q <= cnt_q - 32'h1;
			end
		end
	end

endmodule // cycle_timer

`default_nettype wire

// ===== rtl/pot_serial_command_decoder.v
// Serial command decoder for one 1024-position potentiometer.
// Assumes SPI mode 0 pins sampled by a faster clock; nothing else on the bus.
`timescale 1ns/1ps
`default_nettype none

`include "pot_cmd_defs.vh"

module pot_serial_command_decoder #(
	parameter integer NV_WRITE_CYCLES = `NV_WRITE_TIME_US * (`CLOCK_HZ / 1000000),
	parameter [3:0] TYPE_CODE = 4'hA // Arbitrary value
) (
	input wire clock,
	input wire arst_n,
	input wire cs_n,
	input wire sck,
	input wire si,
	input wire wp_n,
	input wire [1:0] pin_addr,
	output reg so_out,
	output reg so_oe_n,
	output reg [`POS_W-1:0] wiper_pos,
	output wire write_in_progress
);

	localparam integer WIPER_DELAY_CYCLES = (`WIPER_DELAY_NS * (`CLOCK_HZ / 1000000) + 999) / 1000;

	localparam [4:0] ST_IDLE = 5'h01;
	localparam [4:0] ST_ID = 5'h02;
	localparam [4:0] ST_INSTR = 5'h04;
	localparam [4:0] ST_DATA = 5'h08;
	localparam [4:0] ST_SKIP = 5'h10;

	function [`CMD_W-1:0] decode_cmd;
		input rw;
		input [7:0] b;
		reg tail_ok;
		begin
			decode_cmd = {`CMD_W{1'b0}};
			tail_ok = (b[1:0] == 2'b00);
			if (rw && b == `INS_RD_WIPER)
				decode_cmd[`C_RD_WIPER] = 1'b1;
			if (!rw && b == `INS_WR_WIPER)
				decode_cmd[`C_WR_WIPER] = 1'b1;
			if (rw && tail_ok && b[`INS_OP_HI:`INS_OP_LO] == `OP_RD_NV)
				decode_cmd[`C_RD_NV] = 1'b1;
			if (!rw && tail_ok && b[`INS_OP_HI:`INS_OP_LO] == `OP_WR_NV)
				decode_cmd[`C_WR_NV] = 1'b1;
			if (rw && tail_ok && b[`INS_OP_HI:`INS_OP_LO] == `OP_TRANSFER_TO_WIPER)
				decode_cmd[`C_TRANSFER_TO_WIPER] = 1'b1;
			if (!rw && tail_ok && b[`INS_OP_HI:`INS_OP_LO] == `OP_TRANSFER_TO_NV)
				decode_cmd[`C_TRANSFER_TO_NV] = 1'b1;
			if (rw && b == `INS_RD_STATUS)
				decode_cmd[`C_RD_STATUS] = 1'b1;
		end
	endfunction

	function [5:0] cmd_len;
		input [`CMD_W-1:0] c;
		begin
			if (c[`C_TRANSFER_TO_WIPER] || c[`C_TRANSFER_TO_NV])
				cmd_len = `LEN_SHORT;
			else
				cmd_len = `LEN_LONG;
		end
	endfunction

	function loads_wiper;
		input [`CMD_W-1:0] c;
		begin
			loads_wiper = c[`C_WR_WIPER] | c[`C_TRANSFER_TO_WIPER];
		end
	endfunction

	function writes_nv;
		input [`CMD_W-1:0] c;
		begin
			writes_nv = c[`C_WR_NV] | c[`C_TRANSFER_TO_NV];
		end
	endfunction

	function reads_out;
		input [`CMD_W-1:0] c;
		begin
			reads_out = c[`C_RD_WIPER] | c[`C_RD_NV] | c[`C_RD_STATUS];
		end
	endfunction

	wire [5:0] pins_lvl;
	wire cs_n_f;
	wire sck_f;
	wire si_f;
	wire wp_n_f;
	wire [1:0] addr_f;

	pin_sync #(
		.W(6),
		.INIT(`SYNC_INIT)
	) u_sync (
		.clock(clock),
		.arst_n(arst_n),
		.pin_in({cs_n, sck, si, wp_n, pin_addr}),
		.level(pins_lvl)
	);

	assign cs_n_f = pins_lvl[5];
	assign sck_f = pins_lvl[4];
	assign si_f = pins_lvl[3];
	assign wp_n_f = pins_lvl[2];
	assign addr_f = pins_lvl[1:0];

	reg cs_prev_q;
	reg sck_prev_q;
	reg [4:0] state_q;
	reg [5:0] cnt_q;
	reg [7:0] byte_q;
	reg [15:0] data_q;
	reg [15:0] tx_q;
	reg [`CMD_W-1:0] cmd_q;
	reg [1:0] sel_q;
	reg rw_q;
	reg [`POS_W-1:0] wiper_reg_q;
	reg [`POS_W-1:0] nv_q [0:`NV_COUNT-1];
	reg recall_q;
	integer i;

	wire cs_fall = cs_prev_q & ~cs_n_f;
	wire cs_rise = ~cs_prev_q & cs_n_f;
	wire sck_rise = ~sck_prev_q & sck_f & ~cs_n_f;
	wire sck_fall = sck_prev_q & ~sck_f & ~cs_n_f;
	wire [7:0] byte_in = {byte_q[6:0], si_f};
	wire [`CMD_W-1:0] cmd_in = decode_cmd(rw_q, byte_in);
	wire frame_full = (state_q == ST_DATA) && (cnt_q == cmd_len(cmd_q));
	// Partial frames never commit; overlong frames still commit
	wire commit = cs_rise & frame_full;
	wire is_read = reads_out(cmd_q);
	wire nv_busy;
	// Refused writes leave the register untouched and start no busy time
	wire nv_ok = wp_n_f & ~nv_busy;
	wire nv_start = commit & nv_ok & writes_nv(cmd_q);
	wire wiper_load = commit & loads_wiper(cmd_q);
	wire wiper_done;

	assign write_in_progress = nv_busy;

	// Edge history of the filtered pins
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cs_prev_q <= 1'b1;
			sck_prev_q <= 1'b0;
		end
		else
		begin
			cs_prev_q <= cs_n_f;
			sck_prev_q <= sck_f;
		end
	end

	// Frame sequencer
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= ST_IDLE;
			cnt_q <= 6'h00;
			byte_q <= 8'h00;
			data_q <= 16'h0000;
			tx_q <= 16'h0000;
			cmd_q <= {`CMD_W{1'b0}};
			sel_q <= 2'b00;
			rw_q <= 1'b0;
		end
		else if (cs_fall)
		begin
			state_q <= ST_ID;
			cnt_q <= 6'h00;
			cmd_q <= {`CMD_W{1'b0}};
		end
		else if (cs_rise)
			state_q <= ST_IDLE;
		else if (sck_rise)
		begin
			case (state_q)
				ST_ID:
				begin
					byte_q <= byte_in;
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == `CNT_ID_DONE)
					begin
						rw_q <= byte_in[`ID_RW];
						if (byte_in[`ID_TYPE_HI:`ID_TYPE_LO] == TYPE_CODE &&
							byte_in[`ID_ADDR_HI:`ID_ADDR_LO] == addr_f)
							state_q <= ST_INSTR;
						else
							state_q <= ST_SKIP;
					end
				end
				ST_INSTR:
				begin
					byte_q <= byte_in;
					cnt_q <= cnt_q + 6'h01;
					if (cnt_q == `CNT_INSTR_DONE)
					begin
						cmd_q <= cmd_in;
						sel_q <= byte_in[`INS_SEL_HI:`INS_SEL_LO];
						if (cmd_in == {`CMD_W{1'b0}})
							state_q <= ST_SKIP;
						else
							state_q <= ST_DATA;
						// Read data frozen at the end of the instruction byte
						if (cmd_in[`C_RD_STATUS])
							tx_q <= {15'h0000, nv_busy};
						else if (cmd_in[`C_RD_NV])
							tx_q <= {6'h00, nv_q[byte_in[`INS_SEL_HI:`INS_SEL_LO]]};
						else
							tx_q <= {6'h00, wiper_reg_q};
					end
				end
				ST_DATA:
				begin
					if (cnt_q != cmd_len(cmd_q))
					begin
						cnt_q <= cnt_q + 6'h01;
						data_q <= {data_q[14:0], si_f};
					end
				end
				ST_SKIP:
					state_q <= ST_SKIP;
				ST_IDLE:
					state_q <= ST_IDLE;
				default:
					state_q <= ST_IDLE;
			endcase
		end
		else if (sck_fall && state_q == ST_DATA && is_read)
			tx_q <= {tx_q[14:0], 1'b0};
	end

	// Serial output, driven only during the data bytes of a read
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			so_out <= 1'b0;
			so_oe_n <= 1'b1;
		end
		else if (cs_n_f || state_q != ST_DATA || !is_read)
		begin
			so_out <= 1'b0;
			so_oe_n <= 1'b1;
		end
		else if (sck_fall && cnt_q != cmd_len(cmd_q))
		begin
			so_out <= tx_q[15];
			so_oe_n <= 1'b0;
		end
	end

	// Wiper register and non-volatile position registers
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			recall_q <= 1'b1;
			wiper_reg_q <= `NV_RESET_VAL;
			for (i = 0; i < `NV_COUNT; i = i + 1)
				nv_q[i] <= `NV_RESET_VAL;
		end
		else
		begin
			recall_q <= 1'b0;
			// Power-up recall takes the first clock after reset
			if (recall_q)
				wiper_reg_q <= nv_q[0];
			else if (wiper_load)
			begin
				if (cmd_q[`C_TRANSFER_TO_WIPER])
					wiper_reg_q <= nv_q[sel_q];
				else
					wiper_reg_q <= data_q[`POS_W-1:0];
			end
			if (nv_start)
			begin
				if (cmd_q[`C_TRANSFER_TO_NV])
					nv_q[sel_q] <= wiper_reg_q;
				else
					nv_q[sel_q] <= data_q[`POS_W-1:0];
			end
		end
	end

	cycle_timer #(
		.CYCLES(NV_WRITE_CYCLES)
	) u_nv_timer (
		.clock(clock),
		.arst_n(arst_n),
		.start(nv_start),
		.busy(nv_busy),
		.done()
	);

	cycle_timer #(
		.CYCLES(WIPER_DELAY_CYCLES)
	) u_wiper_timer (
		.clock(clock),
		.arst_n(arst_n),
		.start(wiper_load),
		.busy(),
		.done(wiper_done)
	);

	// Visible wiper follows the register after the response delay
	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
			wiper_pos <= `NV_RESET_VAL;
		else if (recall_q)
			wiper_pos <= nv_q[0];
		else if (wiper_done)
			wiper_pos <= wiper_reg_q;
	end

endmodule // pot_serial_command_decoder

`default_nettype wire

// ===== verif/pot_cmd_asserts.sv
// Checker for the potentiometer command decoder.
// Sees only the top module's ports; bound below.
`timescale 1ns/1ps
`default_nettype none
module pot_cmd_asserts #(
	parameter integer NV_WRITE_CYCLES = 50
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic wp_n,
	input wire logic [1:0] pin_addr,
	input wire logic so_out,
	input wire logic so_oe_n,
	input wire logic [9:0] wiper_pos,
	input wire logic write_in_progress
);
	logic [31:0] busy_q;
	always_ff @(posedge clock or negedge arst_n)
		if (!arst_n)
			busy_q <= 32'h0;
		else
			busy_q <= write_in_progress ? busy_q + 32'h1 : 32'h0;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);
	sequence deselected_s;
		cs_n [*8];
	endsequence
	sequence busy_run_s;
		write_in_progress [*8];
	endsequence
	so_released_a: assert property (deselected_s |-> so_oe_n)
		else $error("serial output driven while deselected");
	so_idle_low_a: assert property (so_oe_n |-> !so_out)
		else $error("serial output not low when released");
	drive_in_frame_a: assert property ($fell(so_oe_n) |-> !cs_n)
		else $error("serial output enabled outside a frame");
	busy_hold_a: assert property ($rose(write_in_progress) |=> busy_run_s)
		else $error("busy flag dropped early");
	busy_length_a: assert property ($fell(write_in_progress) |-> busy_q == NV_WRITE_CYCLES)
		else $error("busy length wrong");
	commit_rise_a: assert property ($rose(write_in_progress) |-> cs_n && $past(cs_n, 2))
		else $error("write started before deselect");
	protect_refuse_a: assert property ($rose(write_in_progress) |-> $past(wp_n, 8))
		else $error("write started while protected");
	wiper_delay_a: assert property ($changed(wiper_pos) |-> cs_n && $past(cs_n, 21))
		else $error("wiper moved too early");
endmodule // pot_cmd_asserts
bind pot_serial_command_decoder pot_cmd_asserts #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) pot_cmd_asserts_i (
	.clock(clock), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
	.pin_addr(pin_addr), .so_out(so_out), .so_oe_n(so_oe_n), .wiper_pos(wiper_pos),
	.write_in_progress(write_in_progress));
`default_nettype wire

// ===== verif/spi_host_model.sv
// Host model: mode 0 frames, 400 ns per bit, msb first.
// Assumes a 50 ns clock; frames are called one at a time.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input wire logic clock,
	output logic cs_n,
	output logic sck,
	output logic si,
	input wire logic so_out,
	input wire logic so_oe_n
);
	logic so_q;
	logic oe_seen;
	logic [15:0] rx;
	initial
	begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end
	// Released line shows the inverse of the last driven level
	always @(posedge clock)
		so_q <= so_oe_n ? so_q : so_out;
	task automatic frame(input logic [31:0] word, input int nbits);
		int i;
		oe_seen = 1'b0;
		rx = 16'h0;
		@(posedge clock) cs_n <= 1'b0;
		repeat (8) @(posedge clock);
		for (i = 0; i < nbits; i++)
		begin
			si <= word[31 - i];
			repeat (4) @(posedge clock);
			sck <= 1'b1;
			repeat (4) @(posedge clock);
			rx = {rx[14:0], so_oe_n ? ~so_q : so_out};
			oe_seen = oe_seen | !so_oe_n;
			sck <= 1'b0;
		end
		repeat (4) @(posedge clock);
		cs_n <= 1'b1;
		repeat (40) @(posedge clock);
	endtask
endmodule // spi_host_model
`default_nettype wire

// ===== verif/pot_serial_command_decoder_tb.sv
// Bench for the command decoder: host model frames, checks at the ports.
// Assumes the host model and checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module pot_serial_command_decoder_tb;
	logic clock;
	logic arst_n;
	logic wp_n;
	logic [1:0] pin_addr;
	logic cs_n;
	logic sck;
	logic si;
	logic so_out;
	logic so_oe_n;
	logic [9:0] wiper_pos;
	logic write_in_progress;
	logic [15:0] rx;
	int n_errors;
	int compares;
	pot_serial_command_decoder #(.NV_WRITE_CYCLES(300), .TYPE_CODE(4'hA)) pot_serial_command_decoder_i (
		.clock(clock), .arst_n(arst_n), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
		.pin_addr(pin_addr), .so_out(so_out), .so_oe_n(so_oe_n), .wiper_pos(wiper_pos),
		.write_in_progress(write_in_progress));
	spi_host_model spi_host_model_i (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si),
		.so_out(so_out), .so_oe_n(so_oe_n));
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	task close_out;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task check(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Frame claiming address 2
	task cmd(input logic rw, input logic [7:0] ins, input logic [9:0] val, input int nbits);
		spi_host_model_i.frame({4'hA, 1'b0, 2'h2, rw, ins, 6'h00, val}, nbits);
		rx = spi_host_model_i.rx;
	endtask
	task wait_idle;
		int k;
		for (k = 0; k < 400 && write_in_progress !== 1'b0; k++)
			@(posedge clock);
		if (write_in_progress !== 1'b0)
		begin
			check("busy timeout", 16'h0, {15'h0, write_in_progress});
			close_out;
		end
	endtask
	initial
	begin
		n_errors = 0;
		compares = 0;
		arst_n = 1'b0;
		wp_n = 1'b1;
		pin_addr = 2'h2;
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		repeat (8) @(posedge clock);
		check("wiper reset", 16'h0, {6'h0, wiper_pos});
		cmd(1'b0, 8'hA0, 10'h3FF, 32);
		check("wiper write", 16'h3FF, {6'h0, wiper_pos});
		cmd(1'b1, 8'h80, 10'h0, 32);
		check("wiper read", 16'h3FF, {6'h0, rx[9:0]});
		cmd(1'b0, 8'hCC, 10'h2A5, 32);
		check("nv busy", 16'h1, {15'h0, write_in_progress});
		cmd(1'b1, 8'h41, 10'h0, 32);
		check("status busy", 16'h1, {8'h0, rx[7:0]});
		wait_idle;
		cmd(1'b1, 8'h41, 10'h0, 32);
		check("status idle", 16'h0, {8'h0, rx[7:0]});
		cmd(1'b1, 8'hAC, 10'h0, 32);
		check("nv3 read", 16'h2A5, {6'h0, rx[9:0]});
		cmd(1'b0, 8'hE4, 10'h0, 16);
		check("copy busy", 16'h1, {15'h0, write_in_progress});
		wait_idle;
		cmd(1'b1, 8'hA4, 10'h0, 32);
		check("nv1 read", 16'h3FF, {6'h0, rx[9:0]});
		cmd(1'b1, 8'hCC, 10'h0, 16);
		check("transfer", 16'h2A5, {6'h0, wiper_pos});
		wp_n <= 1'b0;
		cmd(1'b0, 8'hCC, 10'h155, 32);
		check("protected", 16'h0, {15'h0, write_in_progress});
		wp_n <= 1'b1;
		cmd(1'b1, 8'hAC, 10'h0, 32);
		check("nv3 kept", 16'h2A5, {6'h0, rx[9:0]});
		cmd(1'b0, 8'hA0, 10'h111, 24);
		check("short frame", 16'h2A5, {6'h0, wiper_pos});
		cmd(1'b0, 8'h80, 10'h111, 32);
		check("wrong direction", 16'h2A5, {6'h0, wiper_pos});
		spi_host_model_i.frame({4'h3, 1'b0, 2'h2, 1'b0, 8'hA0, 16'h0001}, 32);
		check("type miss", 16'h2A5, {6'h0, wiper_pos});
		pin_addr <= 2'h1;
		cmd(1'b0, 8'hA0, 10'h001, 32);
		check("addr miss", 16'h2A5, {6'h0, wiper_pos});
		cmd(1'b1, 8'h80, 10'h0, 32);
		check("miss released", 16'h0, {15'h0, spi_host_model_i.oe_seen});
		close_out;
	end
endmodule // pot_serial_command_decoder_tb
`default_nettype wire
